//--- hdl/clock_gen_defines.vh
/*
 * Constants for the serial clock generator: register offsets, field positions,
 * reset values, mode codes and timing figures.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef CLOCK_GEN_DEFINES_VH
`define CLOCK_GEN_DEFINES_VH

// ****************************************
// Register byte offsets on the bus
// ****************************************
`define OFS_DIVISOR_LOW   4'h0
`define OFS_DIVISOR_HIGH  4'h4
`define OFS_CONTROL_A     4'h8
`define OFS_CONTROL_C     4'hc
`define OFS_STATUS        4'h0
`define ADDR_WIDTH        4

// ****************************************
// Field positions
// ****************************************
`define BIT_DOUBLE_SPEED  0
`define BIT_SYNC_MODE     6
`define BIT_CLOCK_POL     0
`define BIT_PIN_DIR       1

// ****************************************
// Reset values
// ****************************************
`define RST_DIVISOR       12'h000
`define RST_CONTROL       8'h00

// ****************************************
// Clock modes
// ****************************************
`define MODE_ASYNC_NORMAL 2'h0
`define MODE_ASYNC_DOUBLE 2'h1
`define MODE_SYNC_MASTER  2'h2
`define MODE_SYNC_SLAVE   2'h3

// ****************************************
// Division ratios and timing
// ****************************************
`define DIV_NORMAL        5'h10
`define DIV_DOUBLE        5'h08
`define DIV_MASTER        5'h02
`define SYNC_DELAY_CYCLES 2
`define CLOCK_PERIOD_NS   100

`endif

//--- hdl/edge_sync.v
/*
 * Two synchroniser registers followed by an edge detector for the external
 * transfer clock. Assumes the input is slower than a quarter of mclk.
 */
`timescale 1ns/10ps
`default_nettype none

module edge_sync (
  // Clock and reset
  input  wire mclk,
  input  wire reset,
  // Pin side
  input  wire pinIn,
  input  wire enable,
  // Edges
  output reg  riseQ,
  output reg  fallQ,
  output reg  levelQ
);

  reg syncA_q;
  reg syncB_q;
  reg prev_q;

  // ****************************************
  // Two-stage sampling and edge detection
  // ****************************************
  always @(posedge mclk) begin
    if (reset || !enable) begin
      syncA_q <= 1'b0;
      syncB_q <= 1'b0;
      prev_q  <= 1'b0;
      riseQ   <= 1'b0;
      fallQ   <= 1'b0;
      levelQ  <= 1'b0;
    end else begin
      syncA_q <= pinIn;
      syncB_q <= syncA_q;
      prev_q  <= syncB_q;
      riseQ   <= syncB_q & ~prev_q;
      fallQ   <= ~syncB_q & prev_q;
      levelQ  <= syncB_q;
    end
  end

endmodule // edge_sync

`default_nettype wire

//--- hdl/usart_clock_generator.v
/*
 * Clock generator of a serial transceiver: baud down-counter, four clock
 * modes, transmit bit clock, receive base tick, transfer clock pin handling,
 * with a classic Wishbone register slave.
 * Assumes one 10 MHz clock, synchronous active-high reset, software keeping
 * double speed cleared in synchronous operation.
 */
// Register access over Wishbone and the address map were decided locally.
// What this block does
// - Four clock modes: normal async, double async, sync master, sync slave.
// - Mode-select bit in control C picks synchronous when set to one.
// - In sync operation pin direction output means master, input means slave.
// - Transfer clock pin neither driven nor sampled in asynchronous mode.
// - Master drives generated clock on pin; slave takes clock from pin.
// - Down-counter reloads divisor at zero and on low divisor write.
// - One tick per zero of counter, rate mclk over divisor plus one.
// - Transmit clock is tick over 16, 8 or 2 by mode.
// - Receiver uses tick directly (both pin edges in slave mode) with 16, 8 or 2 states per bit.
// - Bit rate mclk over 16, 8 or 2 times divisor plus one.
// - Divisor is 12 bits from high and low parts, 0 to 4095.
// - Double speed acts only in asynchronous operation.
// - Double speed receiver takes 8 samples per bit, not 16.
// - Slave clock passes synchroniser and edge detector, three cycles delay to the edge strobes.
// - Polarity bit clear: change on rise, sample on fall; set swaps in slave only, master changes on pin rise either way.
`timescale 1ns/10ps
`default_nettype none
`include "clock_gen_defines.vh"

module usart_clock_generator #(
  parameter DIV_WIDTH = 12
) (
  // Clock and reset
  input  wire        mclk,
  input  wire        reset,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [31:0] wb_dat_i,
  input  wire [3:0]  wb_sel_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Transfer clock pin
  input  wire        transferClockPinIn,
  output reg         transferClockPinOut,
  output reg         transferClockPinOe,
  // Clock strobes to transmitter and receiver
  output reg         txBitClock,
  output reg         txDataChange,
  output reg         rxBaseTick,
  output reg         rxSampleEdge,
  output reg  [4:0]  rxStatesPerBit,
  output reg  [1:0]  clockMode
);

  // ****************************************
  // Registers
  // ****************************************
  reg [DIV_WIDTH-1:0] baudDivisor_q;
  reg                 doubleSpeed_q;
  reg                 syncModeSelect_q;
  reg                 syncClockPolarity_q;
  reg                 pinDirection_q;
  reg [DIV_WIDTH-1:0] count_q;
  reg                 reload_q;
  reg [3:0]           txDiv_q;
  reg                 masterClk_q;

  wire       access;
  wire       lowWrite;
  wire [1:0] mode;
  wire       tick;
  wire       slaveRise;
  wire       slaveFall;
  wire       slaveLevel;
  wire       isSync;
  wire       isMaster;
  wire       isSlave;

  assign access   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign lowWrite = access & wb_we_i & wb_sel_i[0] &
                    (wb_adr_i == `OFS_DIVISOR_LOW);

  // ****************************************
  // Mode decode
  // ****************************************
  assign isSync   = syncModeSelect_q;
  assign isMaster = isSync & pinDirection_q;
  assign isSlave  = isSync & ~pinDirection_q;
  assign mode = isMaster ? `MODE_SYNC_MASTER :
                isSlave  ? `MODE_SYNC_SLAVE  :
                doubleSpeed_q ? `MODE_ASYNC_DOUBLE :
                `MODE_ASYNC_NORMAL;

  // ****************************************
  // Register writes
  // ****************************************
  always @(posedge mclk) begin
    if (reset) begin
      baudDivisor_q       <= `RST_DIVISOR;
      doubleSpeed_q       <= 1'b0;
      syncModeSelect_q    <= 1'b0;
      syncClockPolarity_q <= 1'b0;
      pinDirection_q      <= 1'b0;
    end else if (access && wb_we_i && wb_sel_i[0]) begin
      case (wb_adr_i)
        `OFS_DIVISOR_LOW: begin
          baudDivisor_q[7:0] <= wb_dat_i[7:0];
        end
        `OFS_DIVISOR_HIGH: begin
          baudDivisor_q[DIV_WIDTH-1:8] <= wb_dat_i[DIV_WIDTH-9:0];
        end
        `OFS_CONTROL_A: begin
          doubleSpeed_q <= wb_dat_i[`BIT_DOUBLE_SPEED];
        end
        `OFS_CONTROL_C: begin
          syncModeSelect_q    <= wb_dat_i[`BIT_SYNC_MODE];
          syncClockPolarity_q <= wb_dat_i[`BIT_CLOCK_POL];
          pinDirection_q      <= wb_dat_i[`BIT_PIN_DIR];
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Bus answer, one wait-free cycle
  // ****************************************
  always @(posedge mclk) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= access;
      wb_dat_o <= 32'h00000000;
      if (access && !wb_we_i) begin
        case (wb_adr_i)
          `OFS_DIVISOR_LOW:  wb_dat_o[7:0] <= baudDivisor_q[7:0];
          `OFS_DIVISOR_HIGH: wb_dat_o[DIV_WIDTH-9:0] <= baudDivisor_q[DIV_WIDTH-1:8];
          `OFS_CONTROL_A:    wb_dat_o[`BIT_DOUBLE_SPEED] <= doubleSpeed_q;
          `OFS_CONTROL_C: begin
            wb_dat_o[`BIT_SYNC_MODE] <= syncModeSelect_q;
            wb_dat_o[`BIT_CLOCK_POL] <= syncClockPolarity_q;
            wb_dat_o[`BIT_PIN_DIR]   <= pinDirection_q;
            wb_dat_o[5:4]            <= mode;
          end
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // ****************************************
  // Baud down-counter
  // ****************************************
  always @(posedge mclk) begin
    if (reset) begin
      count_q  <= `RST_DIVISOR;
      reload_q <= 1'b0;
    end else begin
      reload_q <= lowWrite;
      if (reload_q) begin
        count_q <= baudDivisor_q;
      end else if (count_q == {DIV_WIDTH{1'b0}}) begin
        count_q <= baudDivisor_q;
      end else begin
        count_q <= count_q - 1'b1;
      end
    end
  end

  assign tick = (count_q == {DIV_WIDTH{1'b0}}) & ~reload_q;

  // ****************************************
  // External clock input
  // ****************************************
  edge_sync slaveSync (
    .mclk   (mclk),
    .reset  (reset),
    .pinIn  (transferClockPinIn),
    .enable (isSlave),
    .riseQ  (slaveRise),
    .fallQ  (slaveFall),
    .levelQ (slaveLevel)
  );

  // ****************************************
  // Transmit divider and master clock
  // ****************************************
  always @(posedge mclk) begin
    if (reset) begin
      txDiv_q     <= 4'h0;
      masterClk_q <= 1'b0;
    end else if (!isMaster) begin
      masterClk_q <= 1'b0;
      if (tick) begin
        if ((mode == `MODE_ASYNC_DOUBLE && txDiv_q >= 4'h7) || txDiv_q == 4'hf) begin
          txDiv_q <= 4'h0;
        end else begin
          txDiv_q <= txDiv_q + 4'h1;
        end
      end
    end else if (tick) begin
      txDiv_q     <= 4'h0;
      masterClk_q <= ~masterClk_q;
    end
  end

  // ****************************************
  // Output strobes and pin
  // ****************************************
  always @(posedge mclk) begin
    if (reset) begin
      txBitClock          <= 1'b0;
      txDataChange        <= 1'b0;
      rxBaseTick          <= 1'b0;
      rxSampleEdge        <= 1'b0;
      rxStatesPerBit      <= `DIV_NORMAL;
      clockMode           <= `MODE_ASYNC_NORMAL;
      transferClockPinOut <= 1'b0;
      transferClockPinOe  <= 1'b0;
    end else begin
      clockMode           <= mode;
      transferClockPinOe  <= isMaster;
      transferClockPinOut <= isMaster & (masterClk_q ^ syncClockPolarity_q);
      case (mode)
        `MODE_ASYNC_NORMAL: begin
          rxStatesPerBit <= `DIV_NORMAL;
          rxBaseTick     <= tick;
          txBitClock     <= tick & (txDiv_q == 4'hf);
          txDataChange   <= tick & (txDiv_q == 4'hf);
          rxSampleEdge   <= 1'b0;
        end
        `MODE_ASYNC_DOUBLE: begin
          rxStatesPerBit <= `DIV_DOUBLE;
          rxBaseTick     <= tick;
          txBitClock     <= tick & (txDiv_q >= 4'h7);
          txDataChange   <= tick & (txDiv_q >= 4'h7);
          rxSampleEdge   <= 1'b0;
        end
        `MODE_SYNC_MASTER: begin
          rxStatesPerBit <= `DIV_MASTER;
          rxBaseTick     <= tick;
          txBitClock     <= tick & masterClk_q;
          // Pin clock low to high when masterClk_q equals syncClockPolarity_q at the tick
          txDataChange   <= tick & (masterClk_q == syncClockPolarity_q);
          rxSampleEdge   <= tick & (masterClk_q != syncClockPolarity_q);
        end
        `MODE_SYNC_SLAVE: begin
          rxStatesPerBit <= `DIV_MASTER;
          rxBaseTick     <= slaveRise | slaveFall;
          txBitClock     <= slaveRise;
          txDataChange   <= syncClockPolarity_q ? slaveFall : slaveRise;
          rxSampleEdge   <= syncClockPolarity_q ? slaveRise : slaveFall;
        end
        default: begin
          rxStatesPerBit <= `DIV_NORMAL;
          rxBaseTick     <= 1'b0;
          txBitClock     <= 1'b0;
          txDataChange   <= 1'b0;
          rxSampleEdge   <= slaveLevel & 1'b0;
        end
      endcase
    end
  end

endmodule // usart_clock_generator

`default_nettype wire

//--- sim/usart_clock_generator_properties.sv
/* Port checker for the serial clock generator.
   Assumes bind to usart_clock_generator, one clock. */
`timescale 1ns/10ps
`default_nettype none
module usart_clock_generator_properties (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       reset,
  // Bus
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  // Pin and strobes
  input wire logic       transferClockPinIn,
  input wire logic       transferClockPinOe,
  input wire logic       rxBaseTick,
  input wire logic       txDataChange,
  input wire logic       rxSampleEdge,
  input wire logic [4:0] rxStatesPerBit,
  input wire logic [1:0] clockMode
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  reset_mode_a: assert property ($fell(reset) |->
    clockMode == 2'h0 && rxStatesPerBit == 5'h10 && !transferClockPinOe)
    else $error("bad state after reset");
  pin_drive_a: assert property ($stable(clockMode) |->
    transferClockPinOe == (clockMode == 2'h2))
    else $error("pin enable wrong");
  states_bit_a: assert property ($stable(clockMode) |->
    rxStatesPerBit == (clockMode[1] ? 5'h02 : clockMode[0] ? 5'h08 : 5'h10))
    else $error("states per bit wrong");
  async_sample_a: assert property (!clockMode[1] |-> !rxSampleEdge)
    else $error("sample edge in async");
  edges_apart_a: assert property (!(txDataChange && rxSampleEdge))
    else $error("change and sample together");
  slave_edge_a: assert property (clockMode == 2'h3 && $past(clockMode, 6) == 2'h3
    && $changed(transferClockPinIn) |-> ##[1:5] rxBaseTick)
    else $error("slave edge lost");
endmodule // usart_clock_generator_properties
bind usart_clock_generator usart_clock_generator_properties u_props (
  .mclk(mclk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .transferClockPinIn(transferClockPinIn),
  .transferClockPinOe(transferClockPinOe), .rxBaseTick(rxBaseTick),
  .txDataChange(txDataChange), .rxSampleEdge(rxSampleEdge),
  .rxStatesPerBit(rxStatesPerBit), .clockMode(clockMode));
`default_nettype wire

//--- sim/transfer_clock_peer.sv
/* Far-side peer: makes the external transfer clock.
   Assumes the bench merges its pin with the device drive. */
`timescale 1ns/10ps
`default_nettype none
module transfer_clock_peer #(
  parameter int HALF = 5
) (
  // Clock
  input  wire logic mclk,
  // Control and pin
  input  wire logic active,
  output var  logic pin
);
  int cnt = 0;
  initial pin = 1'b0;
  // Slow clock when active, line held low when idle
  always @(posedge mclk) begin
    if (!active) begin
      cnt <= 0;
      pin <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      pin <= ~pin;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule // transfer_clock_peer
`default_nettype wire

//--- sim/tb_usart_clock_generator.sv
/* Bench for the serial clock generator.
   Assumes the checker bind and the peer model. */
`timescale 1ns/10ps
`default_nettype none
module tb_usart_clock_generator;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] rdat;
  logic        ack, pinOut, pinOe, txClk, txChg, rxTick, rxSmp, peerPin;
  logic [4:0]  spb;
  logic [1:0]  mode;
  logic        peerOn = 1'b0;
  logic [31:0] seed = 32'hd500a89f;
  logic [31:0] q, d;
  int          errCount = 0;
  int          samplesChecked = 0;
  int          cycles = 0;
  wire         pinLevel = pinOe ? pinOut : peerPin;

  usart_clock_generator u_dut (
    .mclk(mclk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat),
    .wb_ack_o(ack), .transferClockPinIn(pinLevel), .transferClockPinOut(pinOut),
    .transferClockPinOe(pinOe), .txBitClock(txClk), .txDataChange(txChg),
    .rxBaseTick(rxTick), .rxSampleEdge(rxSmp), .rxStatesPerBit(spb),
    .clockMode(mode));
  transfer_clock_peer #(.HALF(5)) u_peer (.mclk(mclk), .active(peerOn), .pin(peerPin));

  initial forever #50 mclk = ~mclk;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic int ratio(input int m);
    return m == 0 ? 16 : m == 1 ? 8 : 2;
  endfunction

  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      errCount++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask

  task automatic wb(input bit w, input logic [3:0] a, input logic [31:0] v);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= v;
    sel <= 4'hf;
    do @(posedge mclk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic pulse(input bit tx);
    do @(posedge mclk); while ((tx ? txClk : rxTick) !== 1'b1);
  endtask

  task automatic gap(input bit tx, input int exp, input string n);
    int c;
    c = 0;
    repeat (2) pulse(tx);
    do begin
      @(posedge mclk);
      c++;
    end while ((tx ? txClk : rxTick) !== 1'b1);
    chk(n, c, exp);
  endtask

  task finishTest;
    $display("checks %0d mismatches %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      errCount++;
      finishTest();
    end
  end

  initial begin
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    for (int i = 0; i < 16; i += 4) begin
      wb(0, i[3:0], 0);
      chk("reset reg", q, 0);
    end
    wb(0, 4'h2, 0);
    chk("unmapped", q, 0);
    $display("test reset done");
    for (int m = 0; m < 3; m++) begin
      wb(1, 4'h8, {31'h0, m == 1});
      wb(1, 4'hc, m == 2 ? 32'h42 : 32'h0);
      d = xs() & 32'h7;
      wb(1, 4'h4, 0);
      wb(1, 4'h0, d);
      gap(0, d + 1, "tick gap");
      gap(1, ratio(m) * (d + 1), "bit gap");
      if (m == 2) begin
        do @(posedge mclk); while (txChg !== 1'b1);
        chk("master change pin", pinOut, 0);
      end
      wb(0, 4'hc, 0);
      chk("mode", q[5:4], m);
      chk("states", spb, ratio(m));
      $display("test mode %0d done", m);
    end
    wb(1, 4'h4, 32'hf);
    wb(1, 4'h0, 32'hff);
    gap(0, 4096, "max tick");
    wb(0, 4'h4, 0);
    chk("div high", q[3:0], 4'hf);
    $display("test max divisor done");
    peerOn <= 1'b1;
    wb(1, 4'hc, 32'h40);
    repeat (8) @(posedge mclk);
    chk("slave oe", pinOe, 0);
    gap(0, 5, "slave tick");
    gap(1, 10, "slave bit");
    do @(posedge mclk); while (rxSmp !== 1'b1);
    chk("slave sample level", peerPin, 0);
    wb(1, 4'hc, 32'h41);
    gap(0, 5, "slave pol tick");
    do @(posedge mclk); while (rxSmp !== 1'b1);
    chk("slave pol sample level", peerPin, 1);
    $display("test slave done");
    finishTest();
  end
endmodule // tb_usart_clock_generator
`default_nettype wire
